// ===== core/adc_seq_pkg.sv
// constants, field layout and state codes of the converter sequencer control
// assumes an apb slave with 32-bit data and one aligned word per register
package adc_seq_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] CTL1_OFS = 8'h00;
  localparam logic [7:0] FLAG_OFS = 8'h04;
  localparam logic [7:0] IE_OFS = 8'h08;
  localparam logic [7:0] CTL0_OFS = 8'h0C;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int START_LSB = 12;
  localparam int SRC_LSB = 10;
  localparam int PULSE_BIT = 9;
  localparam int INV_BIT = 8;
  localparam int DIV_LSB = 5;
  localparam int CLK_LSB = 3;
  localparam int MODE_LSB = 1;
  localparam int BUSY_BIT = 0;
  localparam int SC_BIT = 0;
  localparam int CONV_EN_BIT = 1;
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [15:0] CTL1_RESET = 16'h0000;
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [15:0] IE_RESET = 16'h0000;
  localparam int SAMPLE_TICKS = 4;
  // ----------------------------------------
  // codes
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_CONVERT = 2'h3,
    ST_NEXT = 2'h2
  } seq_state_t;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_SEQ = 2'h1,
    MODE_REP_SINGLE = 2'h2,
    MODE_REP_SEQ = 2'h3
  } seq_mode_t;
endpackage

// ===== core/conv_clock_divider.sv
// divides a one-cycle tick of the conversion clock by code plus one
// assumes tick_in is a one-cycle pulse on ref_clk
`timescale 1ns/1ps
module conv_clock_divider #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic tick_in,
  input wire logic [W-1:0] div_code,
  // divided tick
  output logic tick_out
);
  logic [W-1:0] count_reg;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg <= '0;
      tick_out <= 1'b0;
    end
    else if (!run)
    begin
      count_reg <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= tick_in && (count_reg == div_code);
      if (tick_in)
        count_reg <= (count_reg == div_code) ? '0 : W'(count_reg + 1'b1);
    end
  end
endmodule

// ===== core/sample_window_timer.sv
// sampling timer: holds the window open for a set number of ticks
// assumes start and tick are one-cycle pulses on ref_clk
`timescale 1ns/1ps
module sample_window_timer #(
  parameter int TICKS = 4
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic tick,
  // window
  output logic window
);
  logic [7:0] cnt_reg;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 8'h00;
      window <= 1'b0;
    end
    else if (start)
    begin
      cnt_reg <= 8'h00;
      window <= 1'b1;
    end
    else if (window && tick)
    begin
      if (cnt_reg == 8'(TICKS - 1))
        window <= 1'b0;
      else
        cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule

// ===== core/adc_sequencer_control_flags.sv
// converter sequencer control, result flags and interrupt enables
// assumes an apb master on ref_clk; pins are synchronised here
//
// Notes on behaviour
// - start slot field picks result slot for single or first conversion
// - trigger source 0 software start, 1..3 the three timer outputs
// - pulse mode 0 window follows trigger, 1 window from sampling timer
// - trigger invert bit inverts the selected trigger before use
// - conversion clock divided by divider field plus one
// - clock source picks internal, auxiliary, main or sub-main clock
// - mode selects single, sequence, repeat single or repeat sequence
// - busy bit high while a sequence, sample or conversion is active
// - configuration fields written only while conversion enable is low
// - result flag of a slot set when that slot gets a result
// - flag clears on slot access or by software write
// - each enable bit gates its flag onto the interrupt
// - start and enable may be set together; start clears once taken
`timescale 1ns/1ps
module adc_sequencer_control_flags #(
  parameter int SAMPLE_TICKS = adc_seq_pkg::SAMPLE_TICKS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // clock source pins
  input wire logic internal_conv_oscillator,
  input wire logic aux_clock,
  input wire logic main_clock,
  input wire logic sub_main_clock,
  // trigger pins
  input wire logic first_timer_output_one,
  input wire logic second_timer_output_zero,
  input wire logic second_timer_output_one,
  // converter core
  input wire logic conv_done,
  input wire logic seq_end,
  input wire logic result_access,
  input wire logic [3:0] result_access_slot,
  output logic sample_window_signal,
  output logic conv_clock_enable,
  output logic [3:0] conv_slot,
  output logic conv_busy_flag,
  // interrupt
  output logic irq
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic [15:0] ctl1_reg;
  logic [15:0] flag_reg;
  logic [15:0] ie_reg;
  logic conv_enable_reg;
  logic sc_reg;
  logic [6:0] pins;
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [6:0] sync3_reg;
  adc_seq_pkg::seq_state_t state_reg;
  logic trig_raw;
  logic trig;
  logic trig_prev_reg;
  logic trig_rise;
  logic clk_tick;
  logic div_tick;
  logic timer_start_reg;
  logic timer_win;
  logic win_src;
  logic start_now;
  logic last_conv;
  logic done_now;
  logic [15:0] set_vec;
  logic [15:0] clr_vec;
  logic [15:0] flag_next;
  logic wr_done;
  logic [1:0] src;
  logic [1:0] clk_sel;
  logic [1:0] mode;
  logic pulse_mode;

  assign src = ctl1_reg[adc_seq_pkg::SRC_LSB +: 2];
  assign clk_sel = ctl1_reg[adc_seq_pkg::CLK_LSB +: 2];
  assign mode = ctl1_reg[adc_seq_pkg::MODE_LSB +: 2];
  assign pulse_mode = ctl1_reg[adc_seq_pkg::PULSE_BIT];
  assign wr_done = psel && penable && pready && pwrite;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  assign pins = {second_timer_output_one, second_timer_output_zero,
                 first_timer_output_one, sub_main_clock, main_clock,
                 aux_clock, internal_conv_oscillator};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
        end
        else
        begin
          sync1_reg[gi] <= pins[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // conversion clock and trigger
  // ----------------------------------------
  assign clk_tick = sync2_reg[clk_sel] && !sync3_reg[clk_sel];

  always_comb
  begin
    case (src)
      2'h0: trig_raw = sc_reg;
      2'h1: trig_raw = sync2_reg[4];
      2'h2: trig_raw = sync2_reg[5];
      2'h3: trig_raw = sync2_reg[6];
      default: trig_raw = 1'b0;
    endcase
  end

  assign trig = trig_raw ^ ctl1_reg[adc_seq_pkg::INV_BIT];
  assign trig_rise = trig && !trig_prev_reg;
  assign win_src = pulse_mode ? timer_win : trig;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      trig_prev_reg <= 1'b0;
    else
      trig_prev_reg <= trig;
  end

  conv_clock_divider #(
    .W(3)
  ) u_div (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(conv_enable_reg),
    .tick_in(clk_tick),
    .div_code(ctl1_reg[adc_seq_pkg::DIV_LSB +: 3]),
    .tick_out(div_tick)
  );

  sample_window_timer #(
    .TICKS(SAMPLE_TICKS)
  ) u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(timer_start_reg),
    .tick(div_tick),
    .window(timer_win)
  );

  assign conv_clock_enable = div_tick;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  assign start_now = conv_enable_reg && trig_rise &&
    (state_reg == adc_seq_pkg::ST_IDLE || state_reg == adc_seq_pkg::ST_NEXT);
  assign done_now = (state_reg == adc_seq_pkg::ST_CONVERT) && conv_done;

  always_comb
  begin
    case (mode)
      adc_seq_pkg::MODE_SINGLE: last_conv = 1'b1;
      adc_seq_pkg::MODE_SEQ: last_conv = seq_end;
      adc_seq_pkg::MODE_REP_SINGLE: last_conv = !conv_enable_reg;
      adc_seq_pkg::MODE_REP_SEQ: last_conv = seq_end && !conv_enable_reg;
      default: last_conv = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= adc_seq_pkg::ST_IDLE;
      conv_slot <= 4'h0;
      conv_busy_flag <= 1'b0;
      sample_window_signal <= 1'b0;
      timer_start_reg <= 1'b0;
    end
    else
    begin
      timer_start_reg <= start_now && pulse_mode;
      case (state_reg)
        adc_seq_pkg::ST_IDLE:
        begin
          sample_window_signal <= 1'b0;
          if (start_now)
          begin
            state_reg <= adc_seq_pkg::ST_SAMPLE;
            conv_slot <= ctl1_reg[adc_seq_pkg::START_LSB +: 4];
            conv_busy_flag <= 1'b1;
          end
        end
        adc_seq_pkg::ST_SAMPLE:
        begin
          sample_window_signal <= win_src;
          if (sample_window_signal && !win_src)
            state_reg <= adc_seq_pkg::ST_CONVERT;
        end
        adc_seq_pkg::ST_CONVERT:
        begin
          sample_window_signal <= 1'b0;
          if (conv_done)
          begin
            if (last_conv)
            begin
              state_reg <= adc_seq_pkg::ST_IDLE;
              conv_busy_flag <= 1'b0;
            end
            else
              state_reg <= adc_seq_pkg::ST_NEXT;
            if (mode == adc_seq_pkg::MODE_REP_SEQ && seq_end)
              conv_slot <= ctl1_reg[adc_seq_pkg::START_LSB +: 4];
            else if (mode == adc_seq_pkg::MODE_SEQ ||
                     mode == adc_seq_pkg::MODE_REP_SEQ)
              conv_slot <= conv_slot + 4'h1;
          end
        end
        adc_seq_pkg::ST_NEXT:
        begin
          sample_window_signal <= 1'b0;
          if (start_now)
            state_reg <= adc_seq_pkg::ST_SAMPLE;
          else if (!conv_enable_reg && mode[1])
          begin
            state_reg <= adc_seq_pkg::ST_IDLE;
            conv_busy_flag <= 1'b0;
          end
        end
        default:
        begin
          state_reg <= adc_seq_pkg::ST_IDLE;
          conv_busy_flag <= 1'b0;
          sample_window_signal <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctl1_reg <= adc_seq_pkg::CTL1_RESET;
    else if (wr_done && paddr == adc_seq_pkg::CTL1_OFS && !conv_enable_reg)
      ctl1_reg <= {pwdata[15:1], 1'b0};
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_enable_reg <= 1'b0;
      sc_reg <= 1'b0;
    end
    else
    begin
      if (wr_done && paddr == adc_seq_pkg::CTL0_OFS)
      begin
        conv_enable_reg <= pwdata[adc_seq_pkg::CONV_EN_BIT];
        sc_reg <= pwdata[adc_seq_pkg::SC_BIT];
      end
      else if (start_now || (sc_reg && src != 2'h0))
        sc_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // flags and interrupt
  // ----------------------------------------
  always_comb
  begin
    set_vec = 16'h0000;
    clr_vec = 16'h0000;
    if (done_now)
      set_vec[conv_slot] = 1'b1;
    if (result_access)
      clr_vec[result_access_slot] = 1'b1;
    if (wr_done && paddr == adc_seq_pkg::FLAG_OFS)
      clr_vec = clr_vec | pwdata[15:0];
    flag_next = (flag_reg & ~clr_vec) | set_vec;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_reg <= adc_seq_pkg::FLAG_RESET;
    else
      flag_reg <= flag_next;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ie_reg <= adc_seq_pkg::IE_RESET;
    else if (wr_done && paddr == adc_seq_pkg::IE_OFS)
      ie_reg <= pwdata[15:0];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(flag_reg & ie_reg);
  end

  // ----------------------------------------
  // apb read path
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (psel && penable && !pready)
      begin
        prdata <= 32'h0000_0000;
        case (paddr)
          adc_seq_pkg::CTL1_OFS:
            prdata <= {16'h0000, ctl1_reg[15:1], conv_busy_flag};
          adc_seq_pkg::FLAG_OFS: prdata <= {16'h0000, flag_reg};
          adc_seq_pkg::IE_OFS: prdata <= {16'h0000, ie_reg};
          adc_seq_pkg::CTL0_OFS: prdata <= {30'h0000_0000, conv_enable_reg, sc_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  cfg_locked_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(conv_enable_reg) |-> ctl1_reg == $past(ctl1_reg))
    else $error("configuration changed while enabled");

  busy_state_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    conv_busy_flag == (state_reg != adc_seq_pkg::ST_IDLE))
    else $error("busy flag disagrees with sequencer");

  first_slot_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == adc_seq_pkg::ST_IDLE && start_now) |=>
      conv_slot == $past(ctl1_reg[15:12]))
    else $error("first slot is not the start slot");

  flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done_now |=> flag_reg[$past(conv_slot)])
    else $error("result flag not set");

  access_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (result_access && !set_vec[result_access_slot]) |=>
      !flag_reg[$past(result_access_slot)])
    else $error("flag not cleared on access");

  irq_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 irq == |($past(flag_reg) & $past(ie_reg)))
    else $error("interrupt not gated by enables");

  start_taken_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (start_now && !wr_done) |=> !sc_reg ##0 state_reg == adc_seq_pkg::ST_SAMPLE)
    else $error("software start not cleared once taken");

  window_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == adc_seq_pkg::ST_SAMPLE && !pulse_mode) |=>
      sample_window_signal == $past(trig))
    else $error("window does not follow trigger");

  trig_invert_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    trig == (ctl1_reg[8] ^ ((src == 2'h0) ? sc_reg : sync2_reg[3 + src])))
    else $error("trigger polarity wrong");
endmodule

// ===== tb/adc_sequencer_control_flags_tb_top.sv
// self-checking bench for the converter sequencer control and result flags
// assumes the design files and adc_seq_pkg are compiled first
`timescale 1ns/1ps
module adc_sequencer_control_flags_tb_top;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic conv_done, seq_end, result_access, rerr;
  logic [3:0] result_access_slot, conv_slot;
  logic [2:0] trig;
  logic [4:0] cyc;
  logic sample_window_signal, conv_clock_enable, conv_busy_flag, irq;
  int num_errors = 0;
  int total_checks = 0;
  int cnt;
  int expn;

  adc_sequencer_control_flags #(.SAMPLE_TICKS(4)) i_adc_sequencer_control_flags (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internal_conv_oscillator(cyc[1]), .aux_clock(cyc[2]), .main_clock(cyc[3]),
    .sub_main_clock(cyc[4]), .first_timer_output_one(trig[0]),
    .second_timer_output_zero(trig[1]), .second_timer_output_one(trig[2]),
    .conv_done(conv_done), .seq_end(seq_end), .result_access(result_access),
    .result_access_slot(result_access_slot), .sample_window_signal(sample_window_signal),
    .conv_clock_enable(conv_clock_enable), .conv_slot(conv_slot),
    .conv_busy_flag(conv_busy_flag), .irq(irq)
  );

  // ----------------------------------------
  // clock and source pin clocks
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) cyc <= cyc + 5'h01;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    chk({31'h0, pslverr}, {31'h0, a > adc_seq_pkg::CTL0_OFS});
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic wait_sig(input int which, input logic v);
    int n;
    n = 0;
    while (((which == 0) ? conv_busy_flag : sample_window_signal) !== v && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, (which == 0) ? conv_busy_flag : sample_window_signal}, {31'h0, v});
  endtask

  task automatic done(input logic e);
    idle(3);
    conv_done <= 1'b1;
    seq_end <= e;
    @(posedge ref_clk);
    conv_done <= 1'b0;
    seq_end <= 1'b0;
    idle(3);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial
  begin
    idle(30000);
    chk(32'h0, 32'h1);
    finish_test;
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    conv_done = 1'b0;
    seq_end = 1'b0;
    result_access = 1'b0;
    result_access_slot = 4'h0;
    trig = 3'h7;
    cyc = 5'h00;
    idle(10);
    rst_n <= 1'b1;
    idle(2);
    // reset values, read-only busy bit, unmapped access
    rd_chk(adc_seq_pkg::CTL1_OFS, 32'h0);
    rd_chk(adc_seq_pkg::FLAG_OFS, 32'h0);
    rd_chk(adc_seq_pkg::IE_OFS, 32'h0);
    apb(1'b1, adc_seq_pkg::CTL1_OFS, 32'hFFFF);
    rd_chk(adc_seq_pkg::CTL1_OFS, 32'hFFFE);
    apb(1'b1, adc_seq_pkg::IE_OFS, 32'hFFFF);
    rd_chk(adc_seq_pkg::IE_OFS, 32'hFFFF);
    apb(1'b1, adc_seq_pkg::IE_OFS, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    $display("test registers done");
    // software started sequence from slot 14, pulse mode
    apb(1'b1, adc_seq_pkg::CTL1_OFS, 32'hE202);
    apb(1'b1, adc_seq_pkg::CTL0_OFS, 32'h3);
    wait_sig(0, 1'b1);
    chk({28'h0, conv_slot}, 32'hE);
    rd_chk(adc_seq_pkg::CTL0_OFS, 32'h2);
    apb(1'b1, adc_seq_pkg::CTL1_OFS, 32'h0);
    rd_chk(adc_seq_pkg::CTL1_OFS, 32'hE203);
    wait_sig(1, 1'b1);
    wait_sig(1, 1'b0);
    done(1'b0);
    chk({31'h0, conv_busy_flag}, 32'h1);
    apb(1'b1, adc_seq_pkg::CTL0_OFS, 32'h3);
    wait_sig(1, 1'b1);
    chk({28'h0, conv_slot}, 32'hF);
    wait_sig(1, 1'b0);
    done(1'b1);
    chk({31'h0, conv_busy_flag}, 32'h0);
    rd_chk(adc_seq_pkg::FLAG_OFS, 32'hC000);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, adc_seq_pkg::IE_OFS, 32'h4000);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, adc_seq_pkg::FLAG_OFS, 32'h4000);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    result_access <= 1'b1;
    result_access_slot <= 4'hF;
    @(posedge ref_clk);
    result_access <= 1'b0;
    rd_chk(adc_seq_pkg::FLAG_OFS, 32'h0);
    apb(1'b1, adc_seq_pkg::CTL0_OFS, 32'h0);
    $display("test sequence done");
    // inverted timer triggers, window follows trigger
    for (int s = 1; s < 4; s++)
    begin
      apb(1'b1, adc_seq_pkg::CTL1_OFS, (s + 8) << 12 | s << 10 | 32'h100);
      apb(1'b1, adc_seq_pkg::CTL0_OFS, 32'h2);
      idle(6);
      chk({31'h0, sample_window_signal}, 32'h0);
      trig[s-1] <= 1'b0;
      wait_sig(1, 1'b1);
      chk({28'h0, conv_slot}, s + 8);
      trig[s-1] <= 1'b1;
      wait_sig(1, 1'b0);
      done(1'b1);
      chk({31'h0, conv_busy_flag}, 32'h0);
      apb(1'b1, adc_seq_pkg::CTL0_OFS, 32'h0);
    end
    rd_chk(adc_seq_pkg::FLAG_OFS, 32'h0E00);
    apb(1'b1, adc_seq_pkg::IE_OFS, 32'h0200);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, adc_seq_pkg::FLAG_OFS, 32'hFFFF);
    $display("test triggers done");
    // repeat modes: keep running, restart slot, stop when enable clears
    for (int m = 2; m < 4; m++)
    begin
      apb(1'b1, adc_seq_pkg::CTL1_OFS, 32'h3200 | m << 1);
      for (int r = 0; r < 2; r++)
      begin
        apb(1'b1, adc_seq_pkg::CTL0_OFS, 32'h3);
        wait_sig(1, 1'b1);
        wait_sig(1, 1'b0);
        done(r[0]);
        chk({28'h0, conv_slot}, (m == 3 && r == 0) ? 32'h4 : 32'h3);
        chk({31'h0, conv_busy_flag}, 32'h1);
      end
      apb(1'b1, adc_seq_pkg::CTL0_OFS, 32'h0);
      idle(2);
      chk({31'h0, conv_busy_flag}, 32'h0);
    end
    rd_chk(adc_seq_pkg::FLAG_OFS, 32'h0018);
    apb(1'b1, adc_seq_pkg::FLAG_OFS, 32'hFFFF);
    $display("test repeat modes done");
    // clock source and divider rates
    for (int k = 0; k < 6; k++)
    begin
      automatic int s = (k < 4) ? k : 0;
      automatic int d = (k < 4) ? 0 : ((k == 4) ? 2 : 7);
      apb(1'b1, adc_seq_pkg::CTL1_OFS, d << 5 | s << 3);
      apb(1'b1, adc_seq_pkg::CTL0_OFS, 32'h2);
      idle(8);
      cnt = 0;
      repeat (1024)
      begin
        @(posedge ref_clk);
        if (conv_clock_enable === 1'b1) cnt++;
      end
      expn = 1024 / ((4 << s) * (d + 1));
      chk((cnt >= expn - 1 && cnt <= expn + 1) ? expn : cnt, expn);
      apb(1'b1, adc_seq_pkg::CTL0_OFS, 32'h0);
    end
    $display("test clocks done");
    finish_test;
  end
endmodule
